/* efd_ctrl.sv */
// Purpose: control logic around the external rf field detector
// Assumes: comparator compares rfi level against thr_level, output async
// Notes:   sticky flags clear on flags_rd; a same-cycle event wins
//
// Contract
// - the detector is enabled only via field_detect_enable_sel and raises no events while it is zero.
// - peer detection and collision avoidance thresholds live in separate independently writable fields.
// - the current detector state is always readable as a read-only status bit.
// - each threshold has its own activation and deactivation level.
// - the activation level applies while no field is seen and the deactivation level once it is seen.
// - equal levels give no hysteresis and repeated on/off events are then allowed.
// - the peer detection code spans 75 to 800 mVpp.
// - while peer detection is the enabled selection the detector runs in low-power mode.
// - in peer detection an event is raised both when a field appears and when it disappears.
// - the collision avoidance threshold applies during the field-on avoidance sequence, spanning 25 to 800 mVpp.
// - in passive target mode a field-on detection starts the mask-receive timer.
`timescale 1ns/1ps
module efd_ctrl
  import efd_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [EFD_SEL_W-1:0] field_detect_enable_sel,
  input  wire efd_cfg_t             cfg,
  input  wire logic                 ca_seq_active,
  input  wire logic                 passive_target,
  input  wire logic                 comp_raw,
  input  wire logic                 flags_rd,
  output logic                      det_enable,
  output logic                      low_power,
  output logic                      thr_sel_ca,
  output logic [EFD_THR_W-1:0]      thr_level,
  output efd_stat_t                 status,
  output logic                      field_on_evt,
  output logic                      field_off_evt,
  output logic                      mrt_start
);

  logic       comp_sync;
  logic       enabled;
  logic       use_ca;
  efd_field_t state_q;
  efd_field_t state_d;
  logic       on_flag_q;
  logic       off_flag_q;
  logic       on_evt_q;
  logic       off_evt_q;
  logic       mrt_q;
  logic [3:0] thr_q;
  logic       lp_q;
  logic       ca_q;

  // ----------------------------------------------------------------
  // selection decode
  // ----------------------------------------------------------------
  function automatic logic sel_is_ca(input logic [1:0] sel, input logic ca_seq);
    sel_is_ca = (sel == EFD_SEL_CA) || ((sel == EFD_SEL_AUTO) && ca_seq);
  endfunction : sel_is_ca

  assign enabled = (field_detect_enable_sel != EFD_SEL_OFF);
  assign use_ca  = sel_is_ca(field_detect_enable_sel, ca_seq_active);

  efd_sync u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (comp_raw),
    .sync_out (comp_sync)
  );

  // ----------------------------------------------------------------
  // field state
  // ----------------------------------------------------------------
  always_comb begin
    case (state_q)
      EFD_FIELD_OFF: state_d = (enabled && comp_sync) ? EFD_FIELD_ON : EFD_FIELD_OFF;
      EFD_FIELD_ON:  state_d = (enabled && comp_sync) ? EFD_FIELD_ON : EFD_FIELD_OFF;
      default:       state_d = EFD_FIELD_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= EFD_FIELD_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // threshold selection with hysteresis
  // ----------------------------------------------------------------
  // equal act/deact codes give no hysteresis; chatter is then expected
  always_ff @(posedge clk) begin
    if (rst) begin
      thr_q <= EFD_THR_RST;
      ca_q  <= 1'b0;
      lp_q  <= 1'b0;
    end else begin
      ca_q <= use_ca;
      lp_q <= enabled && !use_ca;
      if (use_ca) begin
        thr_q <= (state_d == EFD_FIELD_ON) ? cfg.ca_deact : cfg.ca_act;
      end else begin
        thr_q <= (state_d == EFD_FIELD_ON) ? cfg.peer_deact : cfg.peer_act;
      end
    end
  end

  // ----------------------------------------------------------------
  // events, sticky flags, mask-receive timer start
  // ----------------------------------------------------------------
  // disabling while on drops the state silently, never an off event
  always_ff @(posedge clk) begin
    if (rst) begin
      on_evt_q  <= 1'b0;
      off_evt_q <= 1'b0;
      mrt_q     <= 1'b0;
    end else begin
      on_evt_q  <= (state_q == EFD_FIELD_OFF) && (state_d == EFD_FIELD_ON);
      off_evt_q <= (state_q == EFD_FIELD_ON) && enabled && !comp_sync;
      mrt_q     <= passive_target && (state_q == EFD_FIELD_OFF) && (state_d == EFD_FIELD_ON);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      on_flag_q  <= 1'b0;
      off_flag_q <= 1'b0;
    end else begin
      on_flag_q  <= on_evt_q || (on_flag_q && !flags_rd);
      off_flag_q <= off_evt_q || (off_flag_q && !flags_rd);
    end
  end

  assign det_enable         = enabled;
  assign low_power          = lp_q;
  assign thr_sel_ca         = ca_q;
  assign thr_level          = thr_q;
  assign status.field_state = state_q;
  assign status.on_flag     = on_flag_q;
  assign status.off_flag    = off_flag_q;
  assign field_on_evt       = on_evt_q;
  assign field_off_evt      = off_evt_q;
  assign mrt_start          = mrt_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  no_evt_off_a: assert property (@(posedge clk) disable iff (rst)
    (field_detect_enable_sel == EFD_SEL_OFF) [*2] |=> !on_evt_q && !off_evt_q)
    else $error("field event while detector disabled");
  thr_indep_a: assert property (@(posedge clk) disable iff (rst)
    (!use_ca && state_d == EFD_FIELD_OFF) |=> thr_q == $past(cfg.peer_act))
    else $error("peer activation level not applied");
  state_follow_a: assert property (@(posedge clk) disable iff (rst)
    (enabled && comp_raw) [*4] |-> status.field_state)
    else $error("status does not show detected field");
  hyst_on_a: assert property (@(posedge clk) disable iff (rst)
    (use_ca && state_d == EFD_FIELD_ON) |=> thr_q == $past(cfg.ca_deact))
    else $error("deactivation level not applied once on");
  lp_peer_a: assert property (@(posedge clk) disable iff (rst)
    (field_detect_enable_sel == EFD_SEL_PEER) |=> low_power)
    else $error("peer detection not in low power");
  on_evt_a: assert property (@(posedge clk) disable iff (rst)
    $rose(status.field_state) |-> field_on_evt)
    else $error("missing field-on event");
  off_evt_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == EFD_FIELD_ON && enabled && !comp_sync) |=> field_off_evt && !status.field_state)
    else $error("missing field-off event");
  mrt_start_a: assert property (@(posedge clk) disable iff (rst)
    (field_on_evt && $past(passive_target)) |-> mrt_start)
    else $error("mrt not started on field-on");
  flag_keep_a: assert property (@(posedge clk) disable iff (rst)
    (field_on_evt && flags_rd) |=> status.on_flag)
    else $error("field-on flag lost on read");
  // a read in the event's own cycle keeps the flag, so clears only hold without an event
  on_flag_set_a: assert property (@(posedge clk) disable iff (rst)
    field_on_evt |=> status.on_flag)
    else $error("field-on flag not set");
  off_flag_set_a: assert property (@(posedge clk) disable iff (rst)
    field_off_evt |=> status.off_flag)
    else $error("field-off flag not set");
  on_flag_clr_a: assert property (@(posedge clk) disable iff (rst)
    (flags_rd && !field_on_evt) |=> !status.on_flag)
    else $error("field-on flag not cleared by read");
  off_flag_clr_a: assert property (@(posedge clk) disable iff (rst)
    (flags_rd && !field_off_evt) |=> !status.off_flag)
    else $error("field-off flag not cleared by read");
  no_state_off_a: assert property (@(posedge clk) disable iff (rst)
    !enabled |=> !status.field_state && !field_off_evt)
    else $error("field state or event while disabled");
  evt_excl_a: assert property (@(posedge clk) disable iff (rst)
    !(field_on_evt && field_off_evt))
    else $error("field-on and field-off in one cycle");
  mrt_cause_a: assert property (@(posedge clk) disable iff (rst)
    mrt_start |-> field_on_evt && $past(passive_target))
    else $error("mrt started without field-on in passive target");
  ca_sel_a: assert property (@(posedge clk) disable iff (rst)
    use_ca |=> thr_sel_ca && !low_power)
    else $error("collision avoidance threshold not selected");
  lp_off_a: assert property (@(posedge clk) disable iff (rst)
    !enabled |=> !low_power)
    else $error("low power while detector disabled");
  peer_deact_a: assert property (@(posedge clk) disable iff (rst)
    (!use_ca && state_d == EFD_FIELD_ON) |=> thr_q == $past(cfg.peer_deact))
    else $error("peer deactivation level not applied once on");
  ca_act_a: assert property (@(posedge clk) disable iff (rst)
    (use_ca && state_d == EFD_FIELD_OFF) |=> thr_q == $past(cfg.ca_act))
    else $error("avoidance activation level not applied");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  // chatter with equal levels is legal, so it is covered, not forbidden
  field_on_c:  cover property (@(posedge clk) disable iff (rst) field_on_evt);
  field_off_c: cover property (@(posedge clk) disable iff (rst) field_off_evt);
  ca_on_c:     cover property (@(posedge clk) disable iff (rst) thr_sel_ca && field_on_evt);
  chatter_c:   cover property (@(posedge clk) disable iff (rst) field_off_evt ##1 field_on_evt);
  mrt_c:       cover property (@(posedge clk) disable iff (rst) mrt_start);

endmodule : efd_ctrl

/* efd_peer.sv */
// Purpose: behavioural peer device whose rf field meets the detector comparator
// Assumes: field level given in the same code units as thr_level
// Notes:   comparator output settles a little after its inputs, as an analog path would
`timescale 1ns/1ps
module efd_peer
  import efd_pkg::*;
(
  input  wire logic [EFD_THR_W-1:0] thr_level,
  input  wire logic [4:0]           field_lvl,
  output logic                      comp_raw
);
  // -------------------------------------------------------
  // comparator, trips only strictly above the code
  // -------------------------------------------------------
  // delay keeps the edge off the clock edge, like a true async input
  assign #1.3 comp_raw = ({1'b0, thr_level} < field_lvl);
endmodule : efd_peer

/* efd_pkg.sv */
// Purpose: shared constants and types for the external field detect control
// Assumes: 200 MHz clk, analog comparator thresholds given as 4-bit codes
// Notes:   codes map linearly across each threshold's span of levels
package efd_pkg;

  // ----------------------------------------------------------------
  // enable selection and threshold widths
  // ----------------------------------------------------------------
  localparam int          EFD_SEL_W   = 2;
  localparam int          EFD_THR_W   = 4;
  localparam logic [1:0]  EFD_SEL_OFF  = 2'h0;
  localparam logic [1:0]  EFD_SEL_PEER = 2'h1;
  localparam logic [1:0]  EFD_SEL_CA   = 2'h2;
  localparam logic [1:0]  EFD_SEL_AUTO = 2'h3;

  // ----------------------------------------------------------------
  // threshold spans in mV peak-to-peak
  // ----------------------------------------------------------------
  localparam int          EFD_PEER_MIN_MV = 75;
  localparam int          EFD_PEER_MAX_MV = 800;
  localparam int          EFD_CA_MIN_MV   = 25;
  localparam int          EFD_CA_MAX_MV   = 800;

  // ----------------------------------------------------------------
  // reset values and synchroniser depth
  // ----------------------------------------------------------------
  localparam logic [3:0]  EFD_THR_RST = 4'h0;
  localparam int          EFD_SYNC_STAGES = 2;

  typedef enum logic [0:0] {
    EFD_FIELD_OFF = 1'b0,
    EFD_FIELD_ON  = 1'b1
  } efd_field_t;

  typedef struct packed {
    logic [3:0] peer_act;
    logic [3:0] peer_deact;
    logic [3:0] ca_act;
    logic [3:0] ca_deact;
  } efd_cfg_t;

  typedef struct packed {
    logic       field_state;
    logic       on_flag;
    logic       off_flag;
  } efd_stat_t;

endpackage : efd_pkg

/* efd_sync.sv */
// Purpose: two-flop synchroniser for the analog comparator output
// Assumes: input is asynchronous to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module efd_sync
  import efd_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;

  // ----------------------------------------------------------------
  // synchroniser stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : efd_sync

/* test_external_field_detect_ctrl.sv */
// Purpose: self-checking bench for efd_ctrl against an integer reference model
// Assumes: 200 MHz clk, inputs driven at falling edge
// Notes:   a short mid-run reset checks recovery; the timeout counts as a failure
`timescale 1ns/1ps
module test_external_field_detect_ctrl;
  import efd_pkg::*;
  logic       clk, rst, ca_seq_active, passive_target, flags_rd, comp_raw;
  logic       det_enable, low_power, thr_sel_ca, field_on_evt, field_off_evt, mrt_start;
  logic [1:0] sel;
  logic [3:0] thr_level;
  logic [4:0] field_lvl;
  efd_cfg_t   cfg;
  efd_stat_t  status;
  int         error_cnt, compares, cycles, seed, p, i, ca, en;
  int         m_s1, m_s2, m_st, m_on, m_off, m_mrt, m_fon, m_foff, m_lp, m_ca, m_thr;

  efd_ctrl i_dut (.clk(clk), .rst(rst), .field_detect_enable_sel(sel), .cfg(cfg),
    .ca_seq_active(ca_seq_active), .passive_target(passive_target), .comp_raw(comp_raw),
    .flags_rd(flags_rd), .det_enable(det_enable), .low_power(low_power), .thr_sel_ca(thr_sel_ca),
    .thr_level(thr_level), .status(status), .field_on_evt(field_on_evt),
    .field_off_evt(field_off_evt), .mrt_start(mrt_start));
  efd_peer i_peer (.thr_level(thr_level), .field_lvl(field_lvl), .comp_raw(comp_raw));

  // -------------------------------------------------------
  // clock, timeout and reference model
  // -------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    en = (sel != EFD_SEL_OFF);
    ca = (sel == EFD_SEL_CA) || (sel == EFD_SEL_AUTO && ca_seq_active);
    if (rst) begin
      {m_s1, m_s2, m_st, m_on, m_off, m_mrt, m_fon, m_foff, m_lp, m_ca, m_thr} = '0;
    end else begin
      m_fon  = m_on | (m_fon & !flags_rd);
      m_foff = m_off | (m_foff & !flags_rd);
      m_on   = en && !m_st && m_s2;
      m_off  = en && m_st && !m_s2;
      m_mrt  = m_on && passive_target;
      m_st   = en ? m_s2 : 0;
      m_s2   = m_s1;
      m_s1   = comp_raw;
      m_lp   = en && !ca;
      m_ca   = ca;
      m_thr  = ca ? (m_st ? cfg.ca_deact : cfg.ca_act) : (m_st ? cfg.peer_deact : cfg.peer_act);
    end
    // ceiling well above the roughly 2400 cycles the sequence needs
    if (cycles > 5000) begin
      error_cnt++;
      summarize();
    end
  end

  // -------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------
  task check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task pick(output logic [3:0] act, output logic [3:0] deact, input bit same);
    int a, d;
    a = $random(seed) & 15;
    d = same ? a : ($random(seed) & 15);
    act   = 4'((a > d) ? a : d);
    deact = 4'((a > d) ? d : a);
  endtask : pick

  task summarize();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // -------------------------------------------------------
  // main sequence: every selection, then equal levels
  // -------------------------------------------------------
  initial begin
    seed = 32'h4a49d48a;
    {rst, sel, cfg, ca_seq_active, passive_target, flags_rd, field_lvl} = '0;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (p = 0; p < 8; p++) begin
      sel = p[1:0];
      pick(cfg.peer_act, cfg.peer_deact, p >= 4);
      pick(cfg.ca_act, cfg.ca_deact, p >= 4);
      for (i = 0; i < 300; i++) begin
        @(negedge clk);
        check("det_enable", det_enable, 4'(sel != EFD_SEL_OFF));
        check("low_power", low_power, 4'(m_lp));
        check("thr_sel_ca", thr_sel_ca, 4'(m_ca));
        check("thr_level", thr_level, 4'(m_thr));
        check("field_state", status.field_state, 4'(m_st));
        check("field_on_evt", field_on_evt, 4'(m_on));
        check("field_off_evt", field_off_evt, 4'(m_off));
        check("mrt_start", mrt_start, 4'(m_mrt));
        check("on_flag", status.on_flag, 4'(m_fon));
        check("off_flag", status.off_flag, 4'(m_foff));
        // equal levels: hover on the code so events may chatter
        if (p >= 4) field_lvl = {1'b0, thr_level} + 5'($random(seed) & 1);
        else if (i % 8 == 0) field_lvl = 5'(($random(seed) & 32'h7fff) % 18);
        if (i % 40 == 0) ca_seq_active = $random(seed);
        passive_target = $random(seed);
        flags_rd = (($random(seed) & 3) == 0);
        // short mid-run reset, model and design must both recover
        rst = (p == 3 && i >= 100 && i < 102);
      end
    end
    summarize();
  end
endmodule : test_external_field_detect_ctrl
